/* File: verilog/rxd_map.svh */
// Purpose: offsets and field positions of the receive descriptor decoder
// Assumes: 8-bit byte address on the register bus, 32-bit data
// Notes: definitions only
`ifndef RXD_MAP_SVH
`define RXD_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define RXD_OFF_WORD_ONE 8'h00
`define RXD_OFF_WORD_TWO 8'h04
`define RXD_OFF_WORD_THREE 8'h08
`define RXD_OFF_CONTROL 8'h0c
`define RXD_OFF_BUF_ADDR 8'h10
`define RXD_OFF_DECODE_INFO 8'h14
`define RXD_OFF_NEXT_DESC 8'h18
`define RXD_OFF_FRAME_FLAGS 8'h1c
`define RXD_OFF_VALID_MASK 8'h20
`define RXD_OFF_IRQ_STATUS 8'h24
`define RXD_OFF_IRQ_MASK 8'h28

// ****************************************
// descriptor field positions
// ****************************************
`define RXD_CHAIN_BIT 31
`define RXD_VIRT_BIT 30
`define RXD_KIND_BIT 29
`define RXD_SIZE_HI 30
`define RXD_SIZE_LO 16
`define RXD_OFFSET_HI 8
`define RXD_OFFSET_LO 0
`define RXD_PFN_HI 22
`define RXD_PFN_LO 0
`define RXD_WORD_TWO_KEEP 32'h7fff01ff

// ****************************************
// frame flag positions and interrupt bits
// ****************************************
`define RXD_FLAG_W 7
`define RXD_FLAG_RUNT 6
`define RXD_FLAG_LONG 5
`define RXD_FLAG_COLL 4
`define RXD_FLAG_TYPE 3
`define RXD_FLAG_DRIB 2
`define RXD_FLAG_CRC 1
`define RXD_FLAG_REST 0
`define RXD_IRQ_W 5
`define RXD_IRQ_DONE 0
`define RXD_IRQ_CHAIN 1
`define RXD_IRQ_ODD_SIZE 2
`define RXD_IRQ_ODD_ADDR 3
`define RXD_IRQ_FRAME 4
`define RXD_RESP_OKAY 2'b00
`define RXD_RESP_SLVERR 2'b10
`endif

/* File: verilog/rxd_pkg.sv */
// Purpose: shared types of the receive descriptor decoder
// Assumes: nothing beyond the map header
// Notes: gray codes along idle, fetch, done
package rxd_pkg;
    typedef enum logic [1:0]
    {
        rxd_st_idle = 2'b00,
        rxd_st_fetch = 2'b01,
        rxd_st_done = 2'b11
    } rxd_state_type;
    typedef logic [6:0] rxd_flag_type;
endpackage

/* File: verilog/rxd_addr_decode.sv */
// Purpose: combinational split of the addressing words of a receive descriptor
// Assumes: words are held stable by the caller
// Notes: parity checks only flag host mistakes, they change no address
`include "rxd_map.svh"
module rxd_addr_decode
(
    input wire logic [31:0] word_one,
    input wire logic [31:0] word_two,
    input wire logic [31:0] word_three,
    output logic is_chain,
    output logic is_virtual,
    output logic pte_sys_virtual,
    output logic [14:0] buf_size,
    output logic [8:0] page_off,
    output logic odd_size,
    output logic odd_addr
);
    import rxd_pkg::*;
    always_comb
    begin
        is_chain = word_one[`RXD_CHAIN_BIT];
        is_virtual = word_one[`RXD_VIRT_BIT];
        // kind bit only matters under virtual addressing
        pte_sys_virtual = word_one[`RXD_VIRT_BIT] & word_one[`RXD_KIND_BIT];
        buf_size = word_two[`RXD_SIZE_HI:`RXD_SIZE_LO];
        page_off = word_two[`RXD_OFFSET_HI:`RXD_OFFSET_LO];
        odd_size = buf_size[0];
        if (word_one[`RXD_VIRT_BIT])
        begin
            odd_addr = page_off[0];
        end
        else
        begin
            odd_addr = word_three[0];
        end
    end
endmodule

/* File: verilog/rxd_status_valid.sv */
// Purpose: per-condition validity of the receive status flags
// Assumes: several conditions may be reported together; meaningless wins
// Notes: bit order follows the flag positions of the map header
`include "rxd_map.svh"
module rxd_status_valid
(
    input wire logic cond_overflow,
    input wire logic cond_late_collision,
    input wire logic cond_runt,
    input wire logic cond_short_runt,
    input wire logic cond_watchdog,
    output rxd_pkg::rxd_flag_type valid_mask
);
    import rxd_pkg::*;
    always_comb
    begin
        valid_mask = '1;
        if (cond_overflow)
        begin
            valid_mask[`RXD_FLAG_RUNT] = 1'b0;
            valid_mask[`RXD_FLAG_COLL] = 1'b0;
            valid_mask[`RXD_FLAG_DRIB] = 1'b0;
            valid_mask[`RXD_FLAG_CRC] = 1'b0;
        end
        if (cond_watchdog)
        begin
            valid_mask[`RXD_FLAG_COLL] = 1'b0;
            valid_mask[`RXD_FLAG_DRIB] = 1'b0;
            valid_mask[`RXD_FLAG_CRC] = 1'b0;
        end
        if (cond_late_collision || cond_runt)
        begin
            valid_mask[`RXD_FLAG_DRIB] = 1'b0;
            valid_mask[`RXD_FLAG_CRC] = 1'b0;
        end
        if (cond_short_runt)
        begin
            valid_mask[`RXD_FLAG_TYPE] = 1'b0;
            valid_mask[`RXD_FLAG_DRIB] = 1'b0;
            valid_mask[`RXD_FLAG_CRC] = 1'b0;
        end
    end
endmodule

/* File: verilog/rxd_decoder.sv */
// Purpose: receive descriptor address decode with an axi4-lite register port
// Assumes: one outstanding page table fetch; pte_data valid while pte_ack is high
// Notes: software loads the three words, then writes control bit 0 to decode
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "rxd_map.svh"

module rxd_decoder
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pte_req,
    output logic [31:0] pte_addr,
    output logic pte_sys_virtual,
    input wire logic pte_ack,
    input wire logic [31:0] pte_data,
    input wire logic frame_done,
    input wire rxd_pkg::rxd_flag_type frame_flags,
    input wire logic cond_overflow,
    input wire logic cond_late_collision,
    input wire logic cond_runt,
    input wire logic cond_short_runt,
    input wire logic cond_watchdog,
    output logic [31:0] rx_buf_addr,
    output logic [14:0] rx_buf_len,
    output logic [31:0] next_desc_addr,
    output logic desc_chained,
    output logic decode_done,
    output logic irq
);
    import rxd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [31:0] word_one_reg, word_two_reg, word_three_reg;
    logic [8:0] page_off_reg;
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [`RXD_IRQ_W-1:0] irq_status_reg, irq_status_next, irq_mask_reg, irq_set;
    rxd_flag_type flags_reg, valid_reg, valid_now;
    rxd_state_type state_reg;
    logic is_chain, is_virtual, kind_sys, odd_size, odd_addr;
    logic [14:0] buf_size;
    logic [8:0] page_off;
    logic wr_fire, start, wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic [31:0] rxd_merge
    (
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    rxd_addr_decode u_decode
    (
        .word_one(word_one_reg),
        .word_two(word_two_reg),
        .word_three(word_three_reg),
        .is_chain(is_chain),
        .is_virtual(is_virtual),
        .pte_sys_virtual(kind_sys),
        .buf_size(buf_size),
        .page_off(page_off),
        .odd_size(odd_size),
        .odd_addr(odd_addr)
    );

    rxd_status_valid u_valid
    (
        .cond_overflow(cond_overflow),
        .cond_late_collision(cond_late_collision),
        .cond_runt(cond_runt),
        .cond_short_runt(cond_short_runt),
        .cond_watchdog(cond_watchdog),
        .valid_mask(valid_now)
    );

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign start = wr_fire && (aw_addr_reg == `RXD_OFF_CONTROL) && w_strb_reg[0] && w_data_reg[0];
    always_comb
    begin
        case (aw_addr_reg)
            `RXD_OFF_WORD_ONE, `RXD_OFF_WORD_TWO, `RXD_OFF_WORD_THREE, `RXD_OFF_CONTROL,
            `RXD_OFF_IRQ_STATUS, `RXD_OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RXD_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RXD_RESP_OKAY : `RXD_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // descriptor words; unused bits of word two are dropped on entry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            word_one_reg <= 32'h00000000;
            word_two_reg <= 32'h00000000;
            word_three_reg <= 32'h00000000;
            irq_mask_reg <= '0;
        end
        else if (wr_fire)
        begin
            case (aw_addr_reg)
                `RXD_OFF_WORD_ONE: word_one_reg <= rxd_merge(word_one_reg, w_data_reg, w_strb_reg);
                `RXD_OFF_WORD_TWO: word_two_reg <= rxd_merge(word_two_reg, w_data_reg, w_strb_reg)
                    & `RXD_WORD_TWO_KEEP;
                `RXD_OFF_WORD_THREE: word_three_reg <= rxd_merge(word_three_reg, w_data_reg,
                    w_strb_reg);
                `RXD_OFF_IRQ_MASK: irq_mask_reg <= w_data_reg[`RXD_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `RXD_OFF_WORD_ONE: rd_word = word_one_reg;
            `RXD_OFF_WORD_TWO: rd_word = word_two_reg;
            `RXD_OFF_WORD_THREE: rd_word = word_three_reg;
            `RXD_OFF_CONTROL: rd_word = {30'h00000000, state_reg};
            `RXD_OFF_BUF_ADDR: rd_word = rx_buf_addr;
            `RXD_OFF_DECODE_INFO: rd_word = {15'h0000, desc_chained, pte_sys_virtual, rx_buf_len};
            `RXD_OFF_NEXT_DESC: rd_word = next_desc_addr;
            `RXD_OFF_FRAME_FLAGS: rd_word = {25'h0000000, flags_reg};
            `RXD_OFF_VALID_MASK: rd_word = {25'h0000000, valid_reg};
            `RXD_OFF_IRQ_STATUS: rd_word = {27'h0000000, irq_status_reg};
            `RXD_OFF_IRQ_MASK: rd_word = {27'h0000000, irq_mask_reg};
            default:
            begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RXD_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RXD_RESP_OKAY : `RXD_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // decode sequence
    // ****************************************
    // a start while a fetch is pending is dropped; software polls control or waits for done
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= rxd_st_idle;
            pte_req <= 1'b0;
            pte_addr <= 32'h00000000;
            pte_sys_virtual <= 1'b0;
            page_off_reg <= 9'h000;
            rx_buf_addr <= 32'h00000000;
            rx_buf_len <= 15'h0000;
            next_desc_addr <= 32'h00000000;
            desc_chained <= 1'b0;
            decode_done <= 1'b0;
        end
        else
        begin
            decode_done <= 1'b0;
            case (state_reg)
                rxd_st_idle:
                begin
                    if (start)
                    begin
                        rx_buf_len <= buf_size;
                        desc_chained <= is_chain;
                        pte_sys_virtual <= kind_sys;
                        page_off_reg <= page_off;
                        if (is_chain)
                        begin
                            next_desc_addr <= word_three_reg;
                            state_reg <= rxd_st_done;
                        end
                        else if (is_virtual)
                        begin
                            pte_req <= 1'b1;
                            pte_addr <= word_three_reg;
                            state_reg <= rxd_st_fetch;
                        end
                        else
                        begin
                            rx_buf_addr <= word_three_reg;
                            state_reg <= rxd_st_done;
                        end
                    end
                end
                rxd_st_fetch:
                begin
                    if (pte_ack)
                    begin
                        pte_req <= 1'b0;
                        rx_buf_addr <= {pte_data[`RXD_PFN_HI:`RXD_PFN_LO], page_off_reg};
                        state_reg <= rxd_st_done;
                    end
                end
                rxd_st_done:
                begin
                    decode_done <= 1'b1;
                    state_reg <= rxd_st_idle;
                end
                default: state_reg <= rxd_st_idle;
            endcase
        end
    end

    // ****************************************
    // frame status and interrupts
    // ****************************************
    // flags that carry no meaning are cleared so software cannot misread them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_reg <= '0;
            valid_reg <= '1;
        end
        else if (frame_done)
        begin
            flags_reg <= frame_flags & valid_now;
            valid_reg <= valid_now;
        end
    end

    always_comb
    begin
        irq_set = '0;
        irq_set[`RXD_IRQ_DONE] = (state_reg == rxd_st_done);
        irq_set[`RXD_IRQ_CHAIN] = (state_reg == rxd_st_done) && desc_chained;
        irq_set[`RXD_IRQ_ODD_SIZE] = start && !is_chain && odd_size;
        irq_set[`RXD_IRQ_ODD_ADDR] = start && !is_chain && odd_addr;
        irq_set[`RXD_IRQ_FRAME] = frame_done;
        irq_status_next = irq_status_reg;
        if (wr_fire && (aw_addr_reg == `RXD_OFF_IRQ_STATUS) && w_strb_reg[0])
        begin
            irq_status_next = irq_status_reg & ~w_data_reg[`RXD_IRQ_W-1:0];
        end
        // a new event in the clearing cycle survives
        irq_status_next = irq_status_next | irq_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status_reg <= irq_status_next;
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    chain_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == rxd_st_idle && start && is_chain) |=> desc_chained
        && next_desc_addr == $past(word_three_reg) ##1 decode_done)
        else $error("chain address not taken from word three");
    direct_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == rxd_st_idle && start && !is_chain && !is_virtual)
        |=> !pte_req && !pte_sys_virtual && rx_buf_addr == $past(word_three_reg))
        else $error("physical buffer address wrong");
    pte_issue_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == rxd_st_idle && start && !is_chain && is_virtual)
        |=> pte_req && pte_addr == $past(word_three_reg))
        else $error("page table fetch not issued");
    pte_kind_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == rxd_st_idle && start && is_virtual)
        |=> pte_sys_virtual == word_one_reg[`RXD_KIND_BIT])
        else $error("entry address kind wrong");
    virt_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pte_req && pte_ack) |=> !pte_req
        && rx_buf_addr[8:0] == page_off_reg ##1 decode_done)
        else $error("translated address lacks page offset");
    buf_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == rxd_st_idle && start) |=> rx_buf_len == word_two_reg[`RXD_SIZE_HI:`RXD_SIZE_LO])
        else $error("buffer length not from word two");
    unused_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        word_two_reg[31] == 1'b0 && word_two_reg[15:9] == 7'h00)
        else $error("unused word two bits kept");
    overflow_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (frame_done && cond_overflow) |=> valid_reg[`RXD_FLAG_LONG] && !valid_reg[`RXD_FLAG_RUNT]
        && !valid_reg[`RXD_FLAG_COLL] && !flags_reg[`RXD_FLAG_CRC])
        else $error("overflow validity wrong");
    late_coll_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (frame_done && cond_late_collision && !cond_overflow && !cond_watchdog
        && !cond_short_runt) |=> valid_reg == 7'h79)
        else $error("late collision validity wrong");
    short_runt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (frame_done && cond_short_runt) |=> !valid_reg[`RXD_FLAG_TYPE]
        && !valid_reg[`RXD_FLAG_DRIB] && !flags_reg[`RXD_FLAG_TYPE])
        else $error("short runt validity wrong");
    odd_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (start && !is_chain && odd_size) |=> irq_status_reg[`RXD_IRQ_ODD_SIZE])
        else $error("odd size not flagged");
endmodule

/* File: tb/rxd_pte_model.sv */
// Purpose: page table responder standing in for host memory
// Assumes: one fetch at a time
// Notes: data is junk outside the ack cycle
module rxd_pte_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic pte_req,
    input wire logic [31:0] pte_addr,
    output logic pte_ack,
    output logic [31:0] pte_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_reg;
    logic served_reg;
    // one ack per request, since req lingers a cycle after it
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !pte_req)
        begin
            wait_reg <= 3'h0;
            served_reg <= 1'b0;
            pte_ack <= 1'b0;
        end
        else if (pte_ack)
        begin
            pte_ack <= 1'b0;
            served_reg <= 1'b1;
        end
        else if (!served_reg && wait_reg >= (slow ? 3'h4 : 3'h0))
            pte_ack <= 1'b1;
        else
            wait_reg <= wait_reg + 3'h1;
    end
    // frame number echoes the entry address so the bench can predict it
    assign pte_data = pte_ack ? {9'h0, pte_addr[22:0]} : ~pte_addr;
endmodule

/* File: tb/rxd_decoder_tb.sv */
// Purpose: self-checking bench of the receive descriptor decoder
// Assumes: pte model answers every fetch
// Notes: the bus master waits for each answer
module rxd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rxd_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, frame_done = 0, slow = 0, cond_watchdog = 0;
    logic cond_overflow = 0, cond_late_collision = 0, cond_runt = 0, cond_short_runt = 0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pte_addr, pte_data, rx_buf_addr;
    logic [31:0] next_desc_addr, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [14:0] rx_buf_len;
    rxd_flag_type frame_flags = 7'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pte_req;
    logic pte_sys_virtual, pte_ack, desc_chained, decode_done, irq;
    int failures = 0, samples_checked = 0;
    rxd_decoder dut_u (.*);
    rxd_pte_model pte_u (.*);
    always #25 aclk = ~aclk;
    // ****************************************
    // shared bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no cycle count is assumed; only the watchdog ends a stuck wait
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        chk(r, (a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h24, 8'h28}) ? 2'b00 : 2'b10, "write resp");
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        chk(r, (a <= 8'h28 && a[1:0] == 2'b00) ? 2'b00 : 2'b10, "read resp");
        s_axi_rready <= 1'b0;
    endtask
    task automatic go(input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3);
        int n;
        wr(8'h00, w1);
        wr(8'h04, w2);
        wr(8'h08, w3);
        wr(8'h0c, 32'h1);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!decode_done && n < 40);
        chk(decode_done, 1, "decode done");
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_phys;
        rd(8'h20, d);
        chk(d, 32'h7f, "reset mask");
        go(32'h2000_0000, 32'hfffe_fffe, 32'h1234_5678);
        chk(rx_buf_addr, 32'h1234_5678, "phys addr");
        chk(rx_buf_len, 15'h7ffe, "length");
        rd(8'h14, d);
        chk(d, 32'h7ffe, "kind ignored");
        rd(8'h04, d);
        chk(d, 32'h7ffe_01fe, "word two");
        $display("test phys done");
    endtask
    task automatic t_virt(input logic k, input logic s);
        slow <= s;
        go({2'b01, k, 29'h0}, 32'h0100_00a4, 32'h0003_0c48);
        chk(pte_addr, 32'h0003_0c48, "pte addr");
        chk(pte_sys_virtual, k, "pte kind");
        chk(rx_buf_addr, {23'h030c48, 9'h0a4}, "virt addr");
        go(32'h8000_0000, 32'h0, 32'hfedc_ba98);
        chk(desc_chained, 1, "chained");
        chk(next_desc_addr, 32'hfedc_ba98, "next desc");
        $display("test virt and chain done");
    endtask
    task automatic t_valid;
        logic [4:0] c[6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h09};
        logic [6:0] m[6] = '{7'h29, 7'h79, 7'h79, 7'h71, 7'h69, 7'h21};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge aclk);
            {cond_watchdog, cond_short_runt, cond_runt} <= c[i][4:2];
            {cond_late_collision, cond_overflow} <= c[i][1:0];
            frame_flags <= 7'h7f;
            frame_done <= 1'b1;
            @(posedge aclk);
            frame_done <= 1'b0;
            rd(8'h20, d);
            chk(d, m[i], "valid mask");
            rd(8'h1c, d);
            chk(d, m[i], "kept flags");
        end
        $display("test validity done");
    endtask
    task automatic t_irq;
        // earlier tests left done, chain and frame bits pending
        wr(8'h24, 32'h1f);
        wr(8'h28, 32'h0);
        go(32'h0, 32'h0001_0000, 32'h0000_0101);
        rd(8'h24, d);
        chk(d, 32'h0000_000d, "odd flags");
        chk(irq, 0, "masked");
        wr(8'h28, 32'h4);
        repeat (2) @(posedge aclk);
        chk(irq, 1, "raised");
        wr(8'h24, 32'h1f);
        repeat (2) @(posedge aclk);
        chk(irq, 0, "cleared");
        go(32'h4000_0000, 32'h0002_0003, 32'h0);
        rd(8'h24, d);
        chk(d, 32'h0000_0009, "odd offset");
        wr(8'h40, 32'h1);
        chk(r, 2'b10, "unmapped write");
        rd(8'h40, d);
        chk(d, 0, "unmapped data");
        $display("test irq done");
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_phys();
        t_virt(0, 0);
        t_virt(1, 1);
        t_valid();
        t_irq();
        conclude();
    end
    // far more than the whole sequence needs
    initial
    begin
        #500000;
        failures++;
        conclude();
    end
endmodule
